/* rtl/backplane_dma_error_logger.sv */
`timescale 1ns/10ps
`include "backplane_err_defs.svh"

module backplane_dma_error_logger #(
  parameter int GRANT_TMO_CYC = `GRANT_TMO_CYC
) (
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     rst_in,
  // local cpu register bus
  input  wire logic [31:0]              cpu_addr_in,
  input  wire logic                     cpu_rd_in,
  input  wire logic                     cpu_wr_in,
  input  wire logic [3:0]               cpu_be_in,
  input  wire logic [31:0]              cpu_wdata_in,
  output logic      [31:0]              cpu_rdata_out,
  output logic                          cpu_ack_out,
  output logic                          cpu_mchk_out,
  // system state from neighbouring registers
  input  wire logic                     halt_line_response_enable_in,
  input  wire logic                     pgood_halt_action_in,
  input  wire logic                     cpu_halted_in,
  input  wire logic                     io_reset_write_reg_in,
  // backplane pins
  input  wire logic                     backplane_halt_line_in,
  input  wire logic                     dc_power_good_in,
  input  wire logic                     bus_grant_in,
  input  wire logic                     bus_reply_in,
  input  wire logic                     bus_parity_err_in,
  // cpu cycle request toward the backplane
  input  wire logic                     cyc_start_in,
  input  wire logic [1:0]               cyc_kind_in,
  input  wire logic [`BUS_PAGE_MSB:0]   cyc_addr_in,
  output logic                          bus_request_out,
  output logic                          cyc_done_out,
  output logic                          cyc_err_out,
  // local memory error events
  input  wire logic                     mem_err_in,
  input  wire logic                     mem_err_lmgh_in,
  input  wire logic                     mem_err_read_in,
  input  wire logic [`MEM_PAGE_W-1:0]   mem_err_page_in,
  input  wire logic                     dma_nxm_in,
  input  wire logic [`MEM_PAGE_W-1:0]   dma_nxm_page_in,
  // error reports
  output logic                          interprocessor_comm_err_out,
  output logic                          lmgh_retry_err_out,
  output logic                          lmgh_write_irq_out,
  output logic [`MEM_PAGE_W-1:0]        local_mem_err_page_out
);

  localparam int REPLY_CYC = `REPLY_TMO_CYC;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic is_demand(input logic [1:0] kind);
    is_demand = (kind == backplane_err_pkg::CYC_DEMAND_RD) ||
                (kind == backplane_err_pkg::CYC_DEMAND_WR);
  endfunction

  // synchronised backplane pins
  logic halt_s;
  logic pgood_s;
  logic grant_s;
  logic reply_s;
  logic parity_s;
  logic pgood_d_r;

  bit_sync2 #(
    .WIDTH (5)
  ) u_pin_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in ({backplane_halt_line_in, dc_power_good_in, bus_grant_in,
                bus_reply_in, bus_parity_err_in}),
    .sync_out ({halt_s, pgood_s, grant_s, reply_s, parity_s})
  );

  // matches the synchroniser's reset level, so no false edge after reset
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pgood_d_r <= 1'b0;
    end else begin
      pgood_d_r <= pgood_s;
    end
  end

  logic pgood_fall;
  assign pgood_fall = pgood_d_r && !pgood_s;

  // backplane cycle sequencer
  backplane_err_pkg::cycle_state_e st_r;
  logic [1:0]                      kind_r;
  logic [`BUS_PAGE_MSB:0]          addr_r;
  logic                            grant_tmo;
  logic                            reply_tmo;

  timeout_counter #(
    .LIMIT (GRANT_TMO_CYC)
  ) u_grant_tmo (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .run_in      (st_r == backplane_err_pkg::ST_WAIT_GRANT),
    .expired_out (grant_tmo)
  );

  timeout_counter #(
    .LIMIT (REPLY_CYC)
  ) u_reply_tmo (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .run_in      (st_r == backplane_err_pkg::ST_WAIT_REPLY),
    .expired_out (reply_tmo)
  );

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_r   <= backplane_err_pkg::ST_IDLE;
      kind_r <= 2'h0;
      addr_r <= '0;
    end else begin
      unique case (st_r)
        backplane_err_pkg::ST_IDLE: begin
          if (cyc_start_in) begin
            st_r   <= backplane_err_pkg::ST_WAIT_GRANT;
            kind_r <= cyc_kind_in;
            addr_r <= cyc_addr_in;
          end
        end
        backplane_err_pkg::ST_WAIT_GRANT: begin
          if (grant_s) begin
            st_r <= backplane_err_pkg::ST_WAIT_REPLY;
          end else if (grant_tmo) begin
            st_r <= backplane_err_pkg::ST_FINISH;
          end
        end
        backplane_err_pkg::ST_WAIT_REPLY: begin
          if (reply_s || reply_tmo) begin
            st_r <= backplane_err_pkg::ST_FINISH;
          end
        end
        backplane_err_pkg::ST_FINISH: begin
          st_r <= backplane_err_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // one-cycle error events from the sequencer
  logic ev_no_grant;
  logic ev_master_nxm;
  logic ev_parity;
  logic any_cyc_err;

  assign ev_no_grant = (st_r == backplane_err_pkg::ST_WAIT_GRANT) &&
                       !grant_s && grant_tmo &&
                       is_demand(kind_r);
  assign ev_master_nxm = (st_r == backplane_err_pkg::ST_WAIT_REPLY) &&
                         !reply_s && reply_tmo &&
                         is_demand(kind_r);
  assign ev_parity = (st_r == backplane_err_pkg::ST_WAIT_REPLY) &&
                     reply_s && parity_s &&
                     (kind_r == backplane_err_pkg::CYC_DEMAND_RD);
  assign any_cyc_err = ((st_r == backplane_err_pkg::ST_WAIT_GRANT) &&
                        !grant_s && grant_tmo) ||
                       ((st_r == backplane_err_pkg::ST_WAIT_REPLY) &&
                        (reply_tmo || (reply_s && parity_s)));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bus_request_out <= 1'b0;
      cyc_done_out    <= 1'b0;
      cyc_err_out     <= 1'b0;
    end else begin
      bus_request_out <= (st_r == backplane_err_pkg::ST_IDLE) ?
                         cyc_start_in :
                         (st_r == backplane_err_pkg::ST_WAIT_GRANT) &&
                         !grant_s && !grant_tmo;
      cyc_done_out    <= (st_r == backplane_err_pkg::ST_FINISH);
      if (st_r == backplane_err_pkg::ST_IDLE) begin
        cyc_err_out <= 1'b0;
      end else if (any_cyc_err) begin
        cyc_err_out <= 1'b1;
      end
    end
  end

  // error log
  logic [31:0] log_r;
  logic [31:0] set_bits;
  logic [31:0] w1c_bits;
  logic        wr_log;
  logic        rd_log;
  logic        hit_page;
  logic        bus_capt_ev;
  logic        mem_capt_ev;
  logic        clear_all;

  assign wr_log   = cpu_wr_in && (cpu_addr_in == `ERR_LOG_ADDR);
  assign rd_log   = cpu_rd_in && (cpu_addr_in == `ERR_LOG_ADDR);
  assign hit_page = cpu_addr_in == `BUS_PAGE_ADDR_ADDR;
  assign bus_capt_ev = ev_parity || ev_master_nxm;
  assign mem_capt_ev = mem_err_in || dma_nxm_in;
  assign clear_all   = io_reset_write_reg_in ||
                       (pgood_fall && cpu_halted_in);

  // byte lanes select which flags a write may clear
  assign w1c_bits = wr_log ?
                    (cpu_wdata_in & be_mask(cpu_be_in) & `LOG_IMPL_MASK) :
                    32'h0000_0000;

  always_comb begin
    set_bits = 32'h0000_0000;
    set_bits[`LOG_HALT_BIT]  = halt_s &&
                               halt_line_response_enable_in;
    set_bits[`LOG_PGOOD_BIT] = pgood_fall &&
                               pgood_halt_action_in;
    set_bits[`LOG_MASTER_NXM_BIT] = ev_master_nxm;
    set_bits[`LOG_PARITY_BIT]     = ev_parity;
    set_bits[`LOG_MEM_ERR_BIT]    = mem_err_in;
    set_bits[`LOG_LOST_BIT] = (bus_capt_ev || mem_capt_ev) &&
                              |(log_r & `LOG_CAPT_MASK);
    set_bits[`LOG_NO_GRANT_BIT] = ev_no_grant;
    set_bits[`LOG_DMA_NXM_BIT]  = dma_nxm_in;
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      log_r <= `LOG_RESET_VAL;
    end else if (clear_all) begin
      log_r <= set_bits;
    end else begin
      log_r <= (log_r & ~w1c_bits) | set_bits;
    end
  end

  // backplane page address of a failing cpu access
  logic [`BUS_PAGE_W-1:0] bus_page_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bus_page_r <= '0;
    end else if (bus_capt_ev && !log_r[`LOG_PARITY_BIT] &&
                 !log_r[`LOG_MASTER_NXM_BIT]) begin
      bus_page_r <= addr_r[`BUS_PAGE_MSB:`BUS_PAGE_LSB];
    end
  end

  // local memory page address, held until both flags clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      local_mem_err_page_out <= '0;
    end else if (mem_capt_ev && !log_r[`LOG_MEM_ERR_BIT] &&
                 !log_r[`LOG_DMA_NXM_BIT]) begin
      local_mem_err_page_out <= mem_err_in ? mem_err_page_in :
                                dma_nxm_page_in;
    end
  end

  // memory error reports
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      interprocessor_comm_err_out <= 1'b0;
      lmgh_retry_err_out          <= 1'b0;
      lmgh_write_irq_out          <= 1'b0;
    end else begin
      interprocessor_comm_err_out <= mem_err_in &&
                                     !mem_err_lmgh_in;
      lmgh_retry_err_out <= mem_err_in && mem_err_lmgh_in &&
                            mem_err_read_in;
      lmgh_write_irq_out <= mem_err_in && mem_err_lmgh_in &&
                            !mem_err_read_in;
    end
  end

  // register bus answer, one cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cpu_rdata_out <= 32'h0000_0000;
      cpu_ack_out   <= 1'b0;
      cpu_mchk_out  <= 1'b0;
    end else begin
      cpu_ack_out  <= cpu_rd_in || cpu_wr_in;
      cpu_mchk_out <= hit_page &&
                      (cpu_wr_in ||
                       (cpu_rd_in && cpu_be_in != 4'hF));
      if (rd_log) begin
        cpu_rdata_out <= log_r & `LOG_IMPL_MASK &
                         be_mask(cpu_be_in);
      end else if (cpu_rd_in && hit_page) begin
        // content only meaningful while parity or timeout flag set
        cpu_rdata_out <= {19'h0_0000, bus_page_r};
      end else begin
        cpu_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // checks
  sequence s_log_read;
    rd_log && cpu_be_in == 4'hF;
  endsequence

  sequence s_page_write;
    cpu_wr_in && hit_page;
  endsequence

  chk_unused_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_log_read |=> (cpu_rdata_out & ~`LOG_IMPL_MASK) == 32'h0)
    else $error("unused log bits read nonzero");

  chk_io_reset_clear: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    io_reset_write_reg_in && set_bits == 32'h0 |=> log_r == 32'h0)
    else $error("log not cleared by io reset");

  chk_write_one_clear: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    wr_log && cpu_be_in[0] && cpu_wdata_in[`LOG_DMA_NXM_BIT] && !dma_nxm_in
    |=> !log_r[`LOG_DMA_NXM_BIT])
    else $error("write one did not clear flag");

  chk_zero_keeps: assert property (@(posedge mclk_in) disable iff (rst_in)
    log_r[`LOG_PARITY_BIT] && !clear_all &&
    !(wr_log && cpu_be_in[0] && cpu_wdata_in[`LOG_PARITY_BIT])
    |=> log_r[`LOG_PARITY_BIT])
    else $error("flag lost without a clear");

  chk_halt_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    halt_s && halt_line_response_enable_in
    |=> log_r[`LOG_HALT_BIT])
    else $error("halt flag not set");

  chk_master_nxm: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_r == backplane_err_pkg::ST_WAIT_REPLY && !reply_s && reply_tmo &&
    is_demand(kind_r)
    |=> log_r[`LOG_MASTER_NXM_BIT] ##1 cyc_done_out && cyc_err_out)
    else $error("reply timeout not logged");

  chk_nondemand_quiet: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    st_r != backplane_err_pkg::ST_IDLE && !is_demand(kind_r)
    |-> !ev_master_nxm && !ev_parity && !ev_no_grant)
    else $error("non demand cycle raised an error");

  chk_lost_error: assert property (@(posedge mclk_in) disable iff (rst_in)
    mem_capt_ev && log_r[`LOG_PARITY_BIT]
    |=> log_r[`LOG_LOST_BIT])
    else $error("lost error not flagged");

  chk_page_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    log_r[`LOG_PARITY_BIT] || log_r[`LOG_MASTER_NXM_BIT]
    |=> $stable(bus_page_r))
    else $error("held page address changed");

  chk_page_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_page_write |=> cpu_mchk_out && cpu_ack_out)
    else $error("page register write without machine check");

endmodule

/* rtl/backplane_err_defs.svh */
`ifndef BACKPLANE_ERR_DEFS_SVH
`define BACKPLANE_ERR_DEFS_SVH

// register byte addresses on the local cpu bus
`define ERR_LOG_ADDR        32'h1008_0004
`define BUS_PAGE_ADDR_ADDR  32'h1008_0008

// error log field positions
`define LOG_HALT_BIT        15
`define LOG_PGOOD_BIT       14
`define LOG_MASTER_NXM_BIT  7
`define LOG_PARITY_BIT      5
`define LOG_MEM_ERR_BIT     4
`define LOG_LOST_BIT        3
`define LOG_NO_GRANT_BIT    2
`define LOG_DMA_NXM_BIT     0

// implemented flags, flags that hold a captured address
`define LOG_IMPL_MASK       32'h0000_C0BD
`define LOG_CAPT_MASK       32'h0000_00B1
`define LOG_RESET_VAL       32'h0000_0000

// page address fields
`define BUS_PAGE_W          13
`define BUS_PAGE_LSB        9
`define BUS_PAGE_MSB        21
`define MEM_PAGE_W          20

// timing
`define CLK_PERIOD_NS       50
`define REPLY_TMO_NS        10000
`define GRANT_TMO_NS        10000000
`define REPLY_TMO_CYC  ((`REPLY_TMO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GRANT_TMO_CYC  ((`GRANT_TMO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/backplane_err_pkg.sv */
package backplane_err_pkg;

  // kind of cpu cycle run on the backplane
  typedef enum logic [1:0] {
    CYC_DEMAND_RD,
    CYC_DEMAND_WR,
    CYC_PREFETCH_RD,
    CYC_INT_ACK
  } cycle_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_GRANT,
    ST_WAIT_REPLY,
    ST_FINISH
  } cycle_state_e;

endpackage

/* rtl/bit_sync2.sv */
`timescale 1ns/10ps
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  // asynchronous levels and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* rtl/timeout_counter.sv */
`timescale 1ns/10ps
module timeout_counter #(
  parameter int LIMIT = 200
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // count while run is high, expire after limit cycles
  input  wire logic run_in,
  output logic      expired_out
);

  localparam int CW = $clog2(LIMIT + 1);

  logic [CW-1:0] count_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in || !run_in) begin
      count_r     <= '0;
      expired_out <= 1'b0;
    end else if (!expired_out) begin
      count_r     <= count_r + CW'(1);
      expired_out <= (count_r == CW'(LIMIT - 1));
    end
  end

endmodule

/* verif/backplane_far_model.sv */
`timescale 1ns/10ps
module backplane_far_model (
  // clock and request from the interface
  input  wire logic       mclk_in,
  input  wire logic       bus_request_in,
  // response controls
  input  wire logic [7:0] grant_dly_in,
  input  wire logic [7:0] reply_dly_in,
  input  wire logic       no_grant_in,
  input  wire logic       no_reply_in,
  input  wire logic       parity_in,
  // backplane pins
  output logic            bus_grant_out,
  output logic            bus_reply_out,
  output logic            bus_parity_err_out
);
  logic [7:0] gcnt_r = 8'h00;
  logic [7:0] rcnt_r = 8'h00;
  logic       req_r  = 1'h0;
  logic       tog_r  = 1'h0;
  logic       win;

  assign win = !no_reply_in && rcnt_r > reply_dly_in &&
               rcnt_r <= reply_dly_in + 8'h03;

  initial begin
    bus_grant_out = 1'h0;
    bus_reply_out = 1'h0;
    bus_parity_err_out = 1'h0;
  end

  // pins move on the falling edge only
  always @(negedge mclk_in) begin
    tog_r <= ~tog_r;
    req_r <= bus_request_in;
    gcnt_r <= bus_request_in ? gcnt_r + 8'h01 : 8'h00;
    bus_grant_out <= bus_request_in && !no_grant_in &&
                     gcnt_r >= grant_dly_in;
    if (req_r && !bus_request_in) begin
      rcnt_r <= 8'h01;
    end else if (rcnt_r != 8'h00 && rcnt_r < reply_dly_in + 8'h04) begin
      rcnt_r <= rcnt_r + 8'h01;
    end else begin
      rcnt_r <= 8'h00;
    end
    bus_reply_out <= win;
    // released parity line keeps moving so no stale level is read
    bus_parity_err_out <= win ? parity_in : tog_r;
  end
endmodule

/* verif/testbench.sv */
`timescale 1ns/10ps
`include "backplane_err_defs.svh"
module testbench;
  localparam int          GTMO = 50;
  localparam logic [31:0] LOG  = `ERR_LOG_ADDR;
  localparam logic [31:0] PGA  = `BUS_PAGE_ADDR_ADDR;
  logic        mclk   = 1'h0;
  logic        rst    = 1'h1;
  logic [31:0] addr   = 32'h0;
  logic        rd     = 1'h0;
  logic        wr     = 1'h0;
  logic [3:0]  be     = 4'h0;
  logic [31:0] wdat   = 32'h0;
  logic        hl_en  = 1'h0;
  logic        pg_act = 1'h0;
  logic        halted = 1'h0;
  logic        iorst  = 1'h0;
  logic        hpin   = 1'h0;
  logic        pgood  = 1'h1;
  logic        start  = 1'h0;
  logic [1:0]  kind   = 2'h0;
  logic [21:0] caddr  = 22'h0;
  logic        merr   = 1'h0;
  logic        lmgh   = 1'h0;
  logic        mrd    = 1'h0;
  logic [19:0] mpage  = 20'h0;
  logic        dnxm   = 1'h0;
  logic [7:0]  gdly   = 8'h00;
  logic [7:0]  rdly   = 8'h01;
  logic        nog    = 1'h0;
  logic        norep  = 1'h0;
  logic        par    = 1'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        mchk;
  logic        grant;
  logic        reply;
  logic        perr;
  logic        breq;
  logic        done;
  logic        cerr;
  logic        ipc;
  logic        retry;
  logic        wirq;
  logic [19:0] pg_out;
  logic [31:0] rdv;
  logic        mk;
  int          err_count  = 0;
  int          num_checks = 0;

  always #25 mclk = ~mclk;

  backplane_dma_error_logger #(.GRANT_TMO_CYC(GTMO)) DUT (
    .mclk_in(mclk), .rst_in(rst), .cpu_addr_in(addr), .cpu_rd_in(rd),
    .cpu_wr_in(wr), .cpu_be_in(be), .cpu_wdata_in(wdat),
    .cpu_rdata_out(rdat), .cpu_ack_out(ack), .cpu_mchk_out(mchk),
    .halt_line_response_enable_in(hl_en), .pgood_halt_action_in(pg_act),
    .cpu_halted_in(halted), .io_reset_write_reg_in(iorst),
    .backplane_halt_line_in(hpin), .dc_power_good_in(pgood),
    .bus_grant_in(grant), .bus_reply_in(reply), .bus_parity_err_in(perr),
    .cyc_start_in(start), .cyc_kind_in(kind), .cyc_addr_in(caddr),
    .bus_request_out(breq), .cyc_done_out(done), .cyc_err_out(cerr),
    .mem_err_in(merr), .mem_err_lmgh_in(lmgh), .mem_err_read_in(mrd),
    .mem_err_page_in(mpage), .dma_nxm_in(dnxm), .dma_nxm_page_in(mpage),
    .interprocessor_comm_err_out(ipc), .lmgh_retry_err_out(retry),
    .lmgh_write_irq_out(wirq), .local_mem_err_page_out(pg_out)
  );

  backplane_far_model far (
    .mclk_in(mclk), .bus_request_in(breq), .grant_dly_in(gdly),
    .reply_dly_in(rdly), .no_grant_in(nog), .no_reply_in(norep),
    .parity_in(par), .bus_grant_out(grant), .bus_reply_out(reply),
    .bus_parity_err_out(perr)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [3:0] e, input logic [31:0] d);
    @(negedge mclk);
    addr = a;
    be = e;
    wdat = d;
    rd = !w;
    wr = w;
    @(negedge mclk);
    rd = 1'h0;
    wr = 1'h0;
    rdv = rdat;
    mk = mchk;
    chk({31'h0, ack}, 32'h1);
  endtask

  task automatic cyc(input logic [1:0] k, input logic [21:0] a,
                     input logic e);
    int n;
    n = 0;
    @(negedge mclk);
    kind = k;
    caddr = a;
    start = 1'h1;
    @(negedge mclk);
    start = 1'h0;
    chk({31'h0, breq}, 32'h1);
    while (done !== 1'h1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk({30'h0, done, cerr}, {30'h0, 1'h1, e});
    @(negedge mclk);
  endtask

  task automatic mev(input logic l, input logic r, input logic [19:0] p,
                     input logic d);
    @(negedge mclk);
    merr = !d;
    lmgh = l;
    mrd = r;
    mpage = p;
    dnxm = d;
    @(negedge mclk);
    merr = 1'h0;
    dnxm = 1'h0;
    chk({29'h0, ipc, retry, wirq},
        d ? 32'h0 : !l ? 32'h4 : r ? 32'h2 : 32'h1);
  endtask

  task automatic rlog(input logic [3:0] e);
    acc(1'h0, LOG, e, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (4) @(negedge mclk);
    rst = 1'h0;
    repeat (3) @(negedge mclk);
    rlog(4'hF);
    chk(rdv, 32'h0);
    acc(1'h0, 32'h1008_000C, 4'hF, 32'h0);
    chk(rdv, 32'h0);
    cyc(2'h0, 22'h00_0200, 1'h0);
    gdly = 8'h14;
    rdly = 8'h1E;
    cyc(2'h1, 22'h00_0400, 1'h0);
    gdly = 8'h00;
    rdly = 8'h01;
    par = 1'h1;
    cyc(2'h0, 22'h2A_5E00, 1'h1);
    par = 1'h0;
    norep = 1'h1;
    cyc(2'h2, 22'h01_0000, 1'h1);
    nog = 1'h1;
    cyc(2'h3, 22'h01_0000, 1'h1);
    rlog(4'hF);
    chk(rdv, 32'h20);
    nog = 1'h0;
    cyc(2'h1, 22'h3F_FE00, 1'h1);
    nog = 1'h1;
    cyc(2'h0, 22'h3F_FE00, 1'h1);
    nog = 1'h0;
    norep = 1'h0;
    rlog(4'hF);
    chk(rdv, 32'hAC);
    acc(1'h0, PGA, 4'hF, 32'h0);
    chk({rdv[30:0], mk}, 32'h2A5E);
    // upper lane write must not touch low flags
    acc(1'h1, LOG, 4'h2, 32'hFFFF_FFFF);
    rlog(4'hF);
    chk(rdv, 32'hAC);
    acc(1'h1, LOG, 4'h1, 32'h0000_0024);
    acc(1'h1, LOG, 4'hF, 32'h0);
    rlog(4'hF);
    chk(rdv, 32'h88);
    acc(1'h1, PGA, 4'hF, 32'h0);
    chk({31'h0, mk}, 32'h1);
    acc(1'h0, PGA, 4'h3, 32'h0);
    chk({31'h0, mk}, 32'h1);
    acc(1'h0, PGA, 4'hF, 32'h0);
    chk(rdv, 32'h152F);
    acc(1'h1, LOG, 4'hF, 32'hFFFF_FFFF);
    rlog(4'hF);
    chk(rdv, 32'h0);
    hpin = 1'h1;
    repeat (6) @(negedge mclk);
    rlog(4'hF);
    chk(rdv, 32'h0);
    hl_en = 1'h1;
    repeat (4) @(negedge mclk);
    rlog(4'hF);
    chk(rdv, 32'h8000);
    hpin = 1'h0;
    hl_en = 1'h0;
    pg_act = 1'h1;
    pgood = 1'h0;
    repeat (6) @(negedge mclk);
    pgood = 1'h1;
    rlog(4'hF);
    chk(rdv, 32'hC000);
    rlog(4'hD);
    chk(rdv, 32'h0);
    mev(1'h0, 1'h1, 20'hABCDE, 1'h0);
    chk({12'h0, pg_out}, 32'hABCDE);
    mev(1'h1, 1'h1, 20'h12345, 1'h0);
    mev(1'h1, 1'h0, 20'h12345, 1'h0);
    mev(1'h0, 1'h0, 20'h12345, 1'h1);
    rlog(4'hF);
    chk(rdv, 32'hC019);
    chk({12'h0, pg_out}, 32'hABCDE);
    acc(1'h1, LOG, 4'hF, 32'h11);
    mev(1'h0, 1'h1, 20'h0F0F0, 1'h0);
    chk({12'h0, pg_out}, 32'h0F0F0);
    rlog(4'hF);
    chk(rdv, 32'hC018);
    @(negedge mclk);
    iorst = 1'h1;
    @(negedge mclk);
    iorst = 1'h0;
    rlog(4'hF);
    chk(rdv, 32'h0);
    mev(1'h0, 1'h0, 20'h00001, 1'h1);
    pg_act = 1'h0;
    halted = 1'h1;
    pgood = 1'h0;
    repeat (6) @(negedge mclk);
    pgood = 1'h1;
    halted = 1'h0;
    rlog(4'hF);
    chk(rdv, 32'h0);
    stop_test();
  end
endmodule
